// file: drs_pkg.sv
/*
 * Constants shared by the reference selector: register offsets, field
 * positions, reset values, loop modes, loop states and timing figures.
 * Assumes a 10 MHz master clock and an APB bus with 32-bit data.
 */
package drs_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_REF_SELECT_CTRL = 8'h00;
	localparam logic [7:0] ADDR_INPUT_PRIORITY_A = 8'h04;
	localparam logic [7:0] ADDR_INPUT_VALID_CTRL = 8'h08;
	localparam logic [7:0] ADDR_INPUT_VALID_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_PRIORITY_TABLE_TOP = 8'h10;
	localparam logic [7:0] ADDR_PRIORITY_TABLE_NEXT = 8'h14;
	localparam logic [7:0] ADDR_LOOP_CTRL = 8'h18;
	localparam logic [7:0] ADDR_RANGE_PPM = 8'h1c;
	localparam logic [7:0] ADDR_PHASE_LOCK_TIMEOUT = 8'h20;
	localparam logic [7:0] ADDR_LOOP_STATE_STATUS = 8'h24;
	localparam logic [7:0] ADDR_LOOP_STATE_STATUS_B = 8'h28;
	localparam logic [7:0] ADDR_INPUT_STATUS = 8'h2c;
	localparam logic [7:0] ADDR_FREQ_REPORT = 8'h30;
	localparam logic [7:0] ADDR_PHASE_REPORT = 8'h34;
	localparam logic [7:0] ADDR_OSC_FREQ_LO = 8'h38;
	localparam logic [7:0] ADDR_OSC_FREQ_HI = 8'h3c;
	// Field positions
	localparam int F_EXT_EN = 0;
	localparam int F_REVERTIVE_EN = 1;
	localparam int F_PIN_SEL = 4;
	localparam int F_MODE = 0;
	localparam int F_HO_BEHAV = 4;
	localparam int F_LOL_FREQ = 5;
	localparam int F_AUTO_RET = 6;
	localparam int F_LATCHED = 4;
	localparam int F_TOP = 4;
	// Reset values
	localparam logic [11:0] RST_PRIORITY = 12'h321;
	localparam logic [2:0] RST_VALID_CTRL = 3'h7;
	localparam logic [9:0] RST_RANGE_PPM = 10'h3e8;
	localparam logic [15:0] RST_PLTO = 16'h000a;
	localparam logic [39:0] RST_OSC_WORD = 40'h80_0000_0000;
	// Loop modes written by software
	localparam logic [1:0] MODE_AUTO = 2'h0;
	localparam logic [1:0] MODE_OPEN = 2'h1;
	localparam logic [1:0] MODE_OSC = 2'h2;
	// Tracking range limits and frequency scaling, one LSB is 0.001 ppb
	localparam logic [9:0] RANGE_MIN_PPM = 10'h001;
	localparam logic [9:0] RANGE_MAX_PPM = 10'h3e8;
	localparam logic [31:0] FREQ_LSB_PER_PPM = 32'h000f_4240;
	// Phase-lock timeout unit: one tick of 1 ms
	localparam int CLK_PERIOD_NS = 100;
	localparam int LOCK_TICK_TIME_NS = 1000000;
	localparam int LOCK_TICK_CYCLES = LOCK_TICK_TIME_NS / CLK_PERIOD_NS;
	// Loop states, one-hot
	typedef enum logic [2:0] {
		ST_TRACK = 3'b001,
		ST_OPEN = 3'b010,
		ST_OSC = 3'b100
	} drs_loop_state_type;
endpackage : drs_pkg

// file: drs_ref_selector.sv
/*
 * Reference selector and loop state control for a three-input digital PLL.
 * Assumes synchronous monitor and pin inputs, an APB master, and a loop
 * datapath that supplies lock, frequency offset and phase.
 */
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns

module drs_ref_selector #(
	parameter int TIMEOUT_TICK_CYCLES = drs_pkg::LOCK_TICK_CYCLES
) (
	// Clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RSTN_I,
	// APB slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// Input monitors and switch pins
	input wire logic [2:0] INPUT_VALID_I,
	input wire logic [3:0] EXT_SWITCH_PINS_I,
	// Loop datapath
	input wire logic PHASE_LOCKED_I,
	input wire logic [31:0] LOOP_FREQ_I,
	input wire logic [31:0] LOOP_PHASE_I,
	// Selection and loop state
	output logic [1:0] SELECTED_REF_O,
	output logic [1:0] TOP_VALID_REF_O,
	output logic TRACKING_O,
	output logic LOSS_OF_LOCK_O,
	output logic HOLDOVER_O,
	output logic RANGE_LIMIT_O,
	output logic OSC_MODE_O,
	output logic [39:0] OSC_FREQ_WORD_O
);

	// All state of the block
	typedef struct packed {
		logic ext_en;
		logic revertive_en;
		logic [1:0] pin_sel;
		logic [11:0] prio;
		logic [2:0] vctrl;
		logic [2:0] vprev;
		logic [2:0] vlatch;
		logic [2:0] lock_timeout_flag;
		logic [1:0] mode;
		logic ho_behav;
		logic lol_freq_en;
		logic auto_ret;
		logic [9:0] range_ppm;
		logic [15:0] plto;
		logic [39:0] osc_word;
		logic [1:0] sel;
		logic [1:0] selout;
		logic [1:0] tab0;
		logic [1:0] tab1;
		logic [1:0] tab2;
		drs_pkg::drs_loop_state_type state;
		logic tracking;
		logic loss_of_lock_flag;
		logic holdover;
		logic range_limit_flag;
		logic locked_once;
		logic [31:0] tick_cnt;
		logic [15:0] to_cnt;
		logic [31:0] freq;
		logic [31:0] phase;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} drs_state_type;

	drs_state_type s_q; // Registered state
	drs_state_type s_d; // Next state
	logic [2:0] elig; // Inputs eligible for automatic selection
	logic [2:0] best_mask; // Eligible inputs at the best priority
	logic [3:0] best_prio; // Best nonzero priority, 4'hf when none
	logic [31:0] freq_abs; // Magnitude of the loop frequency offset
	logic [31:0] limit_lsb; // Range limit in frequency LSBs

	// Priority of input code 1..3, zero for code 0
	function automatic logic [3:0] prio_of(input logic [11:0] p, input logic [1:0] c);
		logic [3:0] r;
		r = 4'h0;
		if (c != 2'd0) begin
			r = p[4*(c-2'd1) +: 4];
		end
		return r;
	endfunction : prio_of

	// First input in circular order after code st that is in mask
	function automatic logic [1:0] next_in_ring(input logic [2:0] mask, input logic [1:0] st);
		logic [1:0] r;
		logic [1:0] c;
		r = 2'd0;
		c = (st == 2'd0) ? 2'd3 : st;
		for (int k = 0; k < 3; k++) begin
			c = (c == 2'd3) ? 2'd1 : c + 2'd1;
			if (mask[c-2'd1] && r == 2'd0) begin
				r = c;
			end
		end
		return r;
	endfunction : next_in_ring

	// Next-state logic: bus, selection, loop state, timeout
	always_comb begin
		logic wr;
		logic [4:0] key [3];
		logic [1:0] pos;
		logic [1:0] pin_code;
		logic cur_ok;
		logic fire;
		s_d = s_q;
		key = '{default: 5'h1f};
		cur_ok = 1'b0;
		wr = PSEL_I && PENABLE_I && PWRITE_I && s_q.pready;
		pos = 2'd0;
		pin_code = 2'd0;
		fire = 1'b0;
		// Eligibility: monitor valid, enabled by software, not timed out, nonzero priority
		for (int i = 0; i < 3; i++) begin
			elig[i] = INPUT_VALID_I[i] && s_q.vctrl[i] && !s_q.lock_timeout_flag[i]
				&& (s_q.prio[4*i +: 4] != 4'h0);
			key[i] = elig[i] ? {1'b0, s_q.prio[4*i +: 4]} : 5'h1f;
		end
		best_prio = 4'hf;
		for (int i = 0; i < 3; i++) begin
			if (elig[i] && s_q.prio[4*i +: 4] < best_prio) begin
				best_prio = s_q.prio[4*i +: 4];
			end
		end
		for (int i = 0; i < 3; i++) begin
			best_mask[i] = elig[i] && (s_q.prio[4*i +: 4] == best_prio);
		end
		// Automatic choice
		cur_ok = (s_q.sel != 2'd0) && elig[s_q.sel-2'd1];
		if (!cur_ok) begin
			s_d.sel = next_in_ring(best_mask, s_q.sel);
		end else if (s_q.revertive_en && prio_of(s_q.prio, s_q.sel) > best_prio) begin
			s_d.sel = next_in_ring(best_mask, s_q.sel);
		end else begin
			s_d.sel = s_q.sel;
		end
		// Priority table sorted by priority, then input order
		s_d.tab0 = 2'd0;
		s_d.tab1 = 2'd0;
		s_d.tab2 = 2'd0;
		for (int i = 0; i < 3; i++) begin
			pos = 2'd0;
			for (int j = 0; j < 3; j++) begin
				if (key[j] < key[i] || (key[j] == key[i] && j < i)) begin
					pos = pos + 2'd1;
				end
			end
			if (elig[i]) begin
				unique case (pos)
					2'd0: s_d.tab0 = 2'(i + 1);
					2'd1: s_d.tab1 = 2'(i + 1);
					default: s_d.tab2 = 2'(i + 1);
				endcase
			end
		end
		// Selected-reference output: pin-driven mux or automatic choice
		pin_code = EXT_SWITCH_PINS_I[s_q.pin_sel] ? ((s_q.prio[3:0] != 4'h0) ? 2'd1 : 2'd3) : 2'd2;
		s_d.selout = s_q.ext_en ? pin_code : s_d.sel;
		// Range limit on the loop frequency offset
		freq_abs = LOOP_FREQ_I[31] ? (32'h0 - LOOP_FREQ_I) : LOOP_FREQ_I;
		limit_lsb = 32'({22'h0, s_q.range_ppm} * drs_pkg::FREQ_LSB_PER_PPM);
		s_d.range_limit_flag = (s_q.state == drs_pkg::ST_TRACK) && (freq_abs >= limit_lsb);
		// Loop state machine
		unique case (s_q.state)
			drs_pkg::ST_TRACK: begin
				// Leave tracking on forced mode or when no reference remains
				if (s_q.mode == drs_pkg::MODE_OSC) begin
					s_d.state = drs_pkg::ST_OSC;
				end else if (s_q.mode == drs_pkg::MODE_OPEN || s_q.selout == 2'd0) begin
					s_d.state = drs_pkg::ST_OPEN;
				end
			end
			drs_pkg::ST_OPEN: begin
				// Return when a reference exists and behaviour allows it
				if (s_q.mode == drs_pkg::MODE_OSC) begin
					s_d.state = drs_pkg::ST_OSC;
				end else if (s_q.mode == drs_pkg::MODE_AUTO && s_q.selout != 2'd0
					&& (s_q.auto_ret || (wr && PADDR_I == drs_pkg::ADDR_LOOP_CTRL))) begin
					s_d.state = drs_pkg::ST_TRACK;
				end
			end
			drs_pkg::ST_OSC: begin
				// Oscillator mode ends into open loop
				if (s_q.mode != drs_pkg::MODE_OSC) begin
					s_d.state = drs_pkg::ST_OPEN;
				end
			end
			default: s_d.state = drs_pkg::ST_OPEN;
		endcase
		// Status flags
		s_d.tracking = (s_d.state == drs_pkg::ST_TRACK);
		s_d.loss_of_lock_flag = (s_q.state != drs_pkg::ST_TRACK) || !PHASE_LOCKED_I
			|| (s_q.lol_freq_en && s_q.range_limit_flag);
		s_d.locked_once = s_q.locked_once || (s_q.state == drs_pkg::ST_TRACK && !s_q.loss_of_lock_flag);
		s_d.holdover = (s_d.state == drs_pkg::ST_OPEN) && s_q.ho_behav && s_q.locked_once;
		// Phase-lock timeout counts ticks while tracking unlocked
		if (s_q.state == drs_pkg::ST_TRACK && s_q.loss_of_lock_flag && s_q.plto != 16'h0
			&& s_q.selout != 2'd0 && s_d.selout == s_q.selout) begin
			if (s_q.tick_cnt >= 32'(TIMEOUT_TICK_CYCLES - 1)) begin
				s_d.tick_cnt = 32'h0;
				s_d.to_cnt = s_q.to_cnt + 16'h1;
				fire = (s_q.to_cnt + 16'h1 >= s_q.plto);
			end else begin
				s_d.tick_cnt = s_q.tick_cnt + 32'h1;
			end
		end else begin
			s_d.tick_cnt = 32'h0;
			s_d.to_cnt = 16'h0;
		end
		if (fire) begin
			s_d.tick_cnt = 32'h0;
			s_d.to_cnt = 16'h0;
		end
		// Live reports
		s_d.freq = LOOP_FREQ_I;
		s_d.phase = LOOP_PHASE_I;
		s_d.vprev = INPUT_VALID_I;
		// Bus writes; hardware sets win over software clears
		s_d.vlatch = s_q.vlatch;
		s_d.lock_timeout_flag = s_q.lock_timeout_flag;
		if (wr) begin
			unique case (PADDR_I)
				drs_pkg::ADDR_REF_SELECT_CTRL: begin
					s_d.ext_en = PWDATA_I[drs_pkg::F_EXT_EN];
					s_d.revertive_en = PWDATA_I[drs_pkg::F_REVERTIVE_EN];
					s_d.pin_sel = PWDATA_I[drs_pkg::F_PIN_SEL +: 2];
				end
				drs_pkg::ADDR_INPUT_PRIORITY_A: s_d.prio = PWDATA_I[11:0];
				drs_pkg::ADDR_INPUT_VALID_CTRL: s_d.vctrl = PWDATA_I[2:0];
				drs_pkg::ADDR_INPUT_VALID_STATUS:
					s_d.vlatch = s_q.vlatch & ~PWDATA_I[drs_pkg::F_LATCHED +: 3];
				drs_pkg::ADDR_LOOP_CTRL: begin
					s_d.mode = PWDATA_I[drs_pkg::F_MODE +: 2];
					s_d.ho_behav = PWDATA_I[drs_pkg::F_HO_BEHAV];
					s_d.lol_freq_en = PWDATA_I[drs_pkg::F_LOL_FREQ];
					s_d.auto_ret = PWDATA_I[drs_pkg::F_AUTO_RET];
				end
				drs_pkg::ADDR_RANGE_PPM: begin
					// Clamp to the supported tracking range
					if (PWDATA_I[9:0] < drs_pkg::RANGE_MIN_PPM || PWDATA_I[31:10] != 22'h0) begin
						s_d.range_ppm = (PWDATA_I[31:10] != 22'h0) ? drs_pkg::RANGE_MAX_PPM
							: drs_pkg::RANGE_MIN_PPM;
					end else if (PWDATA_I[9:0] > drs_pkg::RANGE_MAX_PPM) begin
						s_d.range_ppm = drs_pkg::RANGE_MAX_PPM;
					end else begin
						s_d.range_ppm = PWDATA_I[9:0];
					end
				end
				drs_pkg::ADDR_PHASE_LOCK_TIMEOUT: s_d.plto = PWDATA_I[15:0];
				drs_pkg::ADDR_INPUT_STATUS: s_d.lock_timeout_flag = s_q.lock_timeout_flag & ~PWDATA_I[2:0];
				drs_pkg::ADDR_OSC_FREQ_LO: s_d.osc_word[31:0] = PWDATA_I;
				drs_pkg::ADDR_OSC_FREQ_HI: s_d.osc_word[39:32] = PWDATA_I[7:0];
				default: s_d.pslverr = s_q.pslverr;
			endcase
		end
		s_d.vlatch = s_d.vlatch | (INPUT_VALID_I ^ s_q.vprev);
		if (fire) begin
			s_d.lock_timeout_flag[s_q.selout-2'd1] = 1'b1;
		end
		// Bus answer prepared in the setup cycle
		s_d.pready = PSEL_I && !PENABLE_I;
		s_d.pslverr = 1'b0;
		s_d.prdata = 32'h0;
		if (PSEL_I && !PENABLE_I) begin
			unique case (PADDR_I)
				drs_pkg::ADDR_REF_SELECT_CTRL: s_d.prdata = {26'h0, s_q.pin_sel, 2'h0,
					s_q.revertive_en, s_q.ext_en};
				drs_pkg::ADDR_INPUT_PRIORITY_A: s_d.prdata = {20'h0, s_q.prio};
				drs_pkg::ADDR_INPUT_VALID_CTRL: s_d.prdata = {29'h0, s_q.vctrl};
				drs_pkg::ADDR_INPUT_VALID_STATUS: s_d.prdata = {25'h0, s_q.vlatch, 1'b0,
					INPUT_VALID_I & ~s_q.lock_timeout_flag};
				drs_pkg::ADDR_PRIORITY_TABLE_TOP: s_d.prdata = {26'h0, s_q.tab0, 2'h0,
					s_q.selout};
				drs_pkg::ADDR_PRIORITY_TABLE_NEXT: s_d.prdata = {26'h0, s_q.tab2, 2'h0, s_q.tab1};
				drs_pkg::ADDR_LOOP_CTRL: s_d.prdata = {25'h0, s_q.auto_ret, s_q.lol_freq_en,
					s_q.ho_behav, 2'h0, s_q.mode};
				drs_pkg::ADDR_RANGE_PPM: s_d.prdata = {22'h0, s_q.range_ppm};
				drs_pkg::ADDR_PHASE_LOCK_TIMEOUT: s_d.prdata = {16'h0, s_q.plto};
				drs_pkg::ADDR_LOOP_STATE_STATUS: s_d.prdata = {29'h0, s_q.holdover, s_q.loss_of_lock_flag,
					s_q.tracking};
				drs_pkg::ADDR_LOOP_STATE_STATUS_B: s_d.prdata = {31'h0, s_q.range_limit_flag};
				drs_pkg::ADDR_INPUT_STATUS: s_d.prdata = {29'h0, s_q.lock_timeout_flag};
				drs_pkg::ADDR_FREQ_REPORT: s_d.prdata = s_q.freq;
				drs_pkg::ADDR_PHASE_REPORT: s_d.prdata = s_q.phase;
				drs_pkg::ADDR_OSC_FREQ_LO: s_d.prdata = s_q.osc_word[31:0];
				drs_pkg::ADDR_OSC_FREQ_HI: s_d.prdata = {24'h0, s_q.osc_word[39:32]};
				default: s_d.pslverr = 1'b1; // Unmapped address
			endcase
		end
	end

	// State register
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			s_q <= '0;
			s_q.prio <= drs_pkg::RST_PRIORITY;
			s_q.vctrl <= drs_pkg::RST_VALID_CTRL;
			s_q.range_ppm <= drs_pkg::RST_RANGE_PPM;
			s_q.plto <= drs_pkg::RST_PLTO;
			s_q.osc_word <= drs_pkg::RST_OSC_WORD;
			s_q.state <= drs_pkg::ST_OPEN;
			s_q.loss_of_lock_flag <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register
	assign PRDATA_O = s_q.prdata;
	assign PREADY_O = s_q.pready;
	assign PSLVERR_O = s_q.pslverr;
	assign SELECTED_REF_O = s_q.selout;
	assign TOP_VALID_REF_O = s_q.tab0;
	assign TRACKING_O = s_q.tracking;
	assign LOSS_OF_LOCK_O = s_q.loss_of_lock_flag;
	assign HOLDOVER_O = s_q.holdover;
	assign RANGE_LIMIT_O = s_q.range_limit_flag;
	assign OSC_MODE_O = s_q.state[2];
	assign OSC_FREQ_WORD_O = s_q.osc_word;

	// Checks
	property p_ext_high;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(s_q.ext_en && EXT_SWITCH_PINS_I[s_q.pin_sel])
			|=> (SELECTED_REF_O == (($past(s_q.prio[3:0]) != 4'h0) ? 2'd1 : 2'd3));
	endproperty
	a_ext_high: assert property (p_ext_high) else $error("pin high did not pick input");
	property p_ext_low;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(s_q.ext_en && !EXT_SWITCH_PINS_I[s_q.pin_sel]) |=> (SELECTED_REF_O == 2'd2);
	endproperty
	a_ext_low: assert property (p_ext_low) else $error("pin low did not pick input two");
	property p_prio_zero;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(s_q.sel != 2'd0) |-> (prio_of($past(s_q.prio), s_q.sel) != 4'h0);
	endproperty
	a_prio_zero: assert property (p_prio_zero) else $error("priority zero input chosen");
	property p_lost_switch;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(s_q.sel != 2'd0 && !elig[s_q.sel-2'd1] && best_mask != 3'h0)
			|=> (s_q.sel != $past(s_q.sel))
			&& (prio_of($past(s_q.prio), s_q.sel) == $past(best_prio));
	endproperty
	a_lost_switch: assert property (p_lost_switch) else $error("lost reference kept");
	property p_nonrevert;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(!s_q.revertive_en && s_q.sel != 2'd0 && elig[s_q.sel-2'd1]) |=> $stable(s_q.sel);
	endproperty
	a_nonrevert: assert property (p_nonrevert) else $error("nonrevertive switch seen");
	property p_revertive_en;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(s_q.revertive_en && s_q.sel != 2'd0 && elig[s_q.sel-2'd1]
			&& best_prio < prio_of(s_q.prio, s_q.sel)) |=> !$stable(s_q.sel);
	endproperty
	a_revertive_en: assert property (p_revertive_en) else $error("revertive switch missed");
	sequence s_enter_open;
		(s_q.state == drs_pkg::ST_OPEN) ##0 !TRACKING_O;
	endsequence
	property p_open_loss;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(s_q.state == drs_pkg::ST_TRACK && s_q.mode == drs_pkg::MODE_AUTO && s_q.selout == 2'd0)
			|=> s_enter_open;
	endproperty
	a_open_loss: assert property (p_open_loss) else $error("no open loop on loss");
	property p_lock_timeout_flag_excl;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		$rose(s_q.lock_timeout_flag[0]) |-> $past(s_q.loss_of_lock_flag) && !elig[0];
	endproperty
	a_lock_timeout_flag_excl: assert property (p_lock_timeout_flag_excl) else $error("timed-out input still usable");
	property p_apb_one_wait;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(PSEL_I && !PENABLE_I) |=> PREADY_O ##1 !PREADY_O;
	endproperty
	a_apb_one_wait: assert property (p_apb_one_wait) else $error("bad APB ready timing");

endmodule : drs_ref_selector

// file: drs_src_model.sv
/*
 * Model of the input monitors and the loop datapath lock detector.
 * Assumes the selector feeds back its tracking flag and selected reference.
 */
`timescale 1ns/1ns
module drs_src_model #(
	parameter int LOCK_DELAY = 3
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Requested monitor states and lock permission
	input wire logic [2:0] valid_req_i,
	input wire logic lock_en_i,
	// Feedback from the selector
	input wire logic tracking_i,
	input wire logic [1:0] selected_i,
	// Monitor and lock outputs
	output logic [2:0] valid_o,
	output logic locked_o
);
	logic [3:0] cnt_q; // Cycles settled on one reference
	logic [1:0] ref_q; // Reference seen last cycle
	// Monitors report the requested state at once
	assign valid_o = valid_req_i;
	// Lock only after settling on an unchanged reference, so a switch costs lock
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q <= 4'h0;
			ref_q <= 2'h0;
		end else begin
			ref_q <= selected_i;
			if (!tracking_i || !lock_en_i || ref_q != selected_i) begin
				cnt_q <= 4'h0;
			end else if (cnt_q < 4'(LOCK_DELAY)) begin
				cnt_q <= cnt_q + 4'h1;
			end
		end
	end
	// Lock indication
	assign locked_o = (cnt_q >= 4'(LOCK_DELAY));
endmodule : drs_src_model

// file: tb_dpll_reference_selector.sv
/*
 * Self-checking bench of the reference selector: selection table, then loop states.
 * Assumes the selector answers APB with one access cycle and a 10 MHz clock.
 */
`timescale 1ns/1ns
module tb_dpll_reference_selector;
	// One selection case: settings, monitor states and expected choice
	typedef struct packed {
		logic [11:0] prio;
		logic [7:0] ctrl;
		logic [2:0] vc;
		logic [2:0] vi;
		logic [3:0] pin;
		logic [1:0] sel;
		logic [1:0] top;
	} drs_row_type;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, se;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, freq, phase;
	logic [2:0] valid_req, valid_w;
	logic [3:0] pins;
	logic locked, lock_en, tracking_flag, loss_of_lock_flag, ho, rlim, oscm;
	logic [1:0] sel, top;
	logic [39:0] oscw;
	int err_total, compares, cycles;
	// Rows run in order, each starting from the state the one before left
	drs_row_type rows [16] = '{
		'{12'h321, 8'h00, 3'h7, 3'h7, 4'h0, 2'h1, 2'h1},
		'{12'h321, 8'h00, 3'h7, 3'h6, 4'h0, 2'h2, 2'h2},
		'{12'h321, 8'h00, 3'h7, 3'h7, 4'h0, 2'h2, 2'h1},
		'{12'h321, 8'h02, 3'h7, 3'h7, 4'h0, 2'h1, 2'h1},
		'{12'h321, 8'h00, 3'h7, 3'h7, 4'h0, 2'h1, 2'h1},
		'{12'h321, 8'h00, 3'h2, 3'h7, 4'h0, 2'h2, 2'h2},
		'{12'h111, 8'h02, 3'h7, 3'h7, 4'h0, 2'h2, 2'h1},
		'{12'h111, 8'h02, 3'h7, 3'h3, 4'h0, 2'h2, 2'h1},
		'{12'h111, 8'h02, 3'h7, 3'h1, 4'h0, 2'h1, 2'h1},
		'{12'h111, 8'h02, 3'h7, 3'h7, 4'h0, 2'h1, 2'h1},
		'{12'h111, 8'h02, 3'h7, 3'h6, 4'h0, 2'h2, 2'h2},
		'{12'h230, 8'h02, 3'h7, 3'h7, 4'h0, 2'h3, 2'h3},
		'{12'h321, 8'h21, 3'h7, 3'h0, 4'h4, 2'h1, 2'h0},
		'{12'h321, 8'h23, 3'h7, 3'h1, 4'hb, 2'h2, 2'h1},
		'{12'h320, 8'h21, 3'h7, 3'h6, 4'h4, 2'h3, 2'h2},
		'{12'h321, 8'h00, 3'h7, 3'h0, 4'h0, 2'h0, 2'h0}
	};
	// Device under test, timeout tick shortened to 4 cycles
	drs_ref_selector #(.TIMEOUT_TICK_CYCLES(4)) i_dut (.SYS_CLK_I(clk), .RSTN_I(rstn),
		.PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.INPUT_VALID_I(valid_w), .EXT_SWITCH_PINS_I(pins), .PHASE_LOCKED_I(locked),
		.LOOP_FREQ_I(freq), .LOOP_PHASE_I(phase), .SELECTED_REF_O(sel),
		.TOP_VALID_REF_O(top), .TRACKING_O(tracking_flag), .LOSS_OF_LOCK_O(loss_of_lock_flag), .HOLDOVER_O(ho),
		.RANGE_LIMIT_O(rlim), .OSC_MODE_O(oscm), .OSC_FREQ_WORD_O(oscw));
	// Input sources and lock detector
	drs_src_model i_src (.clk_i(clk), .rstn_i(rstn), .valid_req_i(valid_req),
		.lock_en_i(lock_en), .tracking_i(tracking_flag), .selected_i(sel), .valid_o(valid_w),
		.locked_o(locked));
	// Master clock, 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			err_total++;
			conclude();
		end
	end
	// Prints counts and verdict, ends the run
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude
	// One APB transfer; ready, read data and error are taken at the completing rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		se = pslverr;
		if (n >= 20) begin
			err_total++;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	// Value comparison
	task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Register read and comparison
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, {8'h00, exp}, {8'h00, rd});
	endtask : rchk
	// Settle for n cycles, ending between edges
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	// Main sequence
	initial begin
		rstn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, pins} = '0;
		{freq, phase, valid_req, err_total, compares, cycles} = '0;
		lock_en = 1'b1;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		cyc(1);
		chk("lol_rst", 1, loss_of_lock_flag);
		chk("trk_rst", 0, tracking_flag);
		chk("osc_rst", 40'h80_0000_0000, oscw);
		rchk("prio_rst", drs_pkg::ADDR_INPUT_PRIORITY_A, 32'h321);
		rchk("vc_rst", drs_pkg::ADDR_INPUT_VALID_CTRL, 32'h7);
		rchk("tmo_rst", drs_pkg::ADDR_PHASE_LOCK_TIMEOUT, 32'ha);
		apb(1'b0, 8'h40, 32'h0);
		chk("slverr", 1, se);
		chk("unmapped", 0, rd);
		// Selection table
		foreach (rows[i]) begin
			wr(drs_pkg::ADDR_INPUT_PRIORITY_A, {20'h0, rows[i].prio});
			wr(drs_pkg::ADDR_REF_SELECT_CTRL, {24'h0, rows[i].ctrl});
			wr(drs_pkg::ADDR_INPUT_VALID_CTRL, {29'h0, rows[i].vc});
			valid_req <= rows[i].vi;
			pins <= rows[i].pin;
			cyc(4);
			chk("selected_ref", rows[i].sel, sel);
			chk("top_valid_ref", rows[i].top, top);
			rchk("ptab_top", drs_pkg::ADDR_PRIORITY_TABLE_TOP,
				{26'h0, rows[i].top, 2'h0, rows[i].sel});
		end
		// Tracking, lock, holdover and return
		wr(drs_pkg::ADDR_INPUT_STATUS, 32'h7);
		wr(drs_pkg::ADDR_LOOP_CTRL, 32'h50);
		valid_req <= 3'h7;
		cyc(10);
		chk("trk", 1, tracking_flag);
		chk("lol", 0, loss_of_lock_flag);
		rchk("loop_status", drs_pkg::ADDR_LOOP_STATE_STATUS, 32'h1);
		rchk("ptab_next", drs_pkg::ADDR_PRIORITY_TABLE_NEXT, 32'h32);
		valid_req <= 3'h0;
		cyc(5);
		chk("trk_open", 0, tracking_flag);
		chk("holdover", 1, ho);
		valid_req <= 3'h1;
		cyc(5);
		chk("trk_back", 1, tracking_flag);
		wr(drs_pkg::ADDR_LOOP_CTRL, 32'h51);
		cyc(3);
		chk("trk_forced", 0, tracking_flag);
		// Range edge, clamped minimum and frequency lock criterion
		wr(drs_pkg::ADDR_LOOP_CTRL, 32'h50);
		wr(drs_pkg::ADDR_RANGE_PPM, 32'h0);
		rchk("range_min", drs_pkg::ADDR_RANGE_PPM, 32'h1);
		freq <= 32'd999999;
		cyc(3);
		chk("rlim_below", 0, rlim);
		freq <= 32'd1000000;
		phase <= 32'h1234abcd;
		cyc(3);
		chk("rlim_edge", 1, rlim);
		rchk("freq_rep", drs_pkg::ADDR_FREQ_REPORT, 32'd1000000);
		rchk("phase_rep", drs_pkg::ADDR_PHASE_REPORT, 32'h1234abcd);
		wr(drs_pkg::ADDR_LOOP_CTRL, 32'h70);
		cyc(3);
		chk("lol_freq", 1, loss_of_lock_flag);
		// Lock never reached: every input times out in turn
		freq <= 32'h0;
		lock_en <= 1'b0;
		wr(drs_pkg::ADDR_LOOP_CTRL, 32'h50);
		wr(drs_pkg::ADDR_PHASE_LOCK_TIMEOUT, 32'h2);
		valid_req <= 3'h7;
		cyc(80);
		rchk("lock_tmo", drs_pkg::ADDR_INPUT_STATUS, 32'h7);
		chk("sel_tmo", 0, sel);
		// Oscillator mode with a software frequency word
		wr(drs_pkg::ADDR_LOOP_CTRL, 32'h2);
		wr(drs_pkg::ADDR_OSC_FREQ_LO, 32'h12345678);
		wr(drs_pkg::ADDR_OSC_FREQ_HI, 32'h9a);
		cyc(2);
		chk("osc_mode", 1, oscm);
		chk("osc_word", 40'h9a12345678, oscw);
		conclude();
	end
endmodule : tb_dpll_reference_selector
